// ### rtl/sac_defines.vh
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// register offsets
`define SAC_ADDR_ENABLE 12'h2b0
`define SAC_ADDR_CONFIG 12'h2b1
`define SAC_ADDR_STATUS 12'h2b2

// config fields and reset value
`define SAC_CFG_RESET 8'h05
`define SAC_CFG_AVG_MSB 3
`define SAC_CFG_AVG_LSB 2
`define SAC_CFG_DUR_MSB 1
`define SAC_CFG_DUR_LSB 0

// status fields
`define SAC_ST_COMPLETE 17
`define SAC_ST_INVERT 16
`define SAC_ST_COARSE_MSB 15
`define SAC_ST_COARSE_LSB 8
`define SAC_ST_FINE_MSB 7
`define SAC_ST_FINE_LSB 0

// max sysref period per duration code, device clock cycles
`define SAC_MAX_PERIOD_0 16'd128
`define SAC_MAX_PERIOD_1 16'd1664
`define SAC_MAX_PERIOD_2 16'd7808
`define SAC_MAX_PERIOD_3 16'd32384

// run bound scale: 384 * 19
`define SAC_RUN_SCALE_DEFAULT 32'd7296

`endif

// ### rtl/sac_calibrator.v
// Function
// - average code 0..3 selects 4, 16, 64 or 256 accumulations per run.
// - larger average code gives longer run and lower result spread.
// - duration code 0..3 selects 4, 16, 64 or 256 cycles per accumulation.
// - sysref period must stay within 128, 1664, 7808, 32384 cycles per code.
// - sysref period too long for duration code yields no valid result.
// - run finishes within 384*19*4^(avg+dur+2) device clock cycles.
// - complete flag bit 17 reads one only while enabled and run finished.
// - computed delay in status bits 16:0, meaningful only while complete.
// - result bit 16 shows whether sampling clock inversion was chosen.
// - result bits 15:8 coarse code, bits 7:0 fine code.
// - config register resets to 0x05, both codes equal one.
// - enable rising from zero to one launches a new calibration run.
// - while enabled, applied delay comes from calibration, manual value ignored.
`timescale 1ns/1ps
`include "sac_defines.vh"
`default_nettype none

module sac_calibrator #(
  parameter [31:0] RUN_SCALE = `SAC_RUN_SCALE_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register access port
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [23:0] reg_rdata,
  // timing reference
  input wire sysref,
  // delay control
  input wire [16:0] manual_delay,
  output reg [16:0] sample_delay
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WAIT = 3'd1;
  localparam [2:0] ST_ACCUM = 3'd2;
  localparam [2:0] ST_DONE = 3'd3;
  localparam [2:0] ST_FAIL = 3'd4;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg enable;
  reg enable_prev;
  reg [7:0] cal_config;
  reg complete;
  reg [16:0] result;
  reg [2:0] state;
  reg sysref_prev;
  reg [15:0] period_cnt;
  reg [8:0] dur_cnt;
  reg [8:0] acc_cnt;
  reg [16:0] high_sum;
  reg [7:0] edge_phase;
  reg [31:0] run_cnt;

  wire [1:0] avg_code = cal_config[`SAC_CFG_AVG_MSB:`SAC_CFG_AVG_LSB];
  wire [1:0] dur_code = cal_config[`SAC_CFG_DUR_MSB:`SAC_CFG_DUR_LSB];
  // 4 << 2*code gives 4, 16, 64, 256
  wire [8:0] acc_total = 9'h004 << {avg_code, 1'b0};
  wire [8:0] dur_total = 9'h004 << {dur_code, 1'b0};
  // exponent reaches 16 with both codes at 3, so it needs five bits
  wire [4:0] run_exp = {2'b00, avg_code, 1'b0} + {2'b00, dur_code, 1'b0} + 5'h04;
  wire [31:0] run_limit = RUN_SCALE << run_exp;
  wire sysref_rise = sysref & ~sysref_prev;
  wire launch = enable & ~enable_prev;
  reg [15:0] max_period;
  reg [16:0] avg_high;
  reg [16:0] next_result;

  always @*
  begin
    case (dur_code)
      2'h0: max_period = `SAC_MAX_PERIOD_0;
      2'h1: max_period = `SAC_MAX_PERIOD_1;
      2'h2: max_period = `SAC_MAX_PERIOD_2;
      default: max_period = `SAC_MAX_PERIOD_3;
    endcase
    // more accumulations averaged down reduces spread of the fine code
    // the last sample is still being added on the finishing edge, so fold it in here
    avg_high = (high_sum + {16'h0000, sysref}) >> {avg_code, 1'b0} >> 2;
    next_result = 17'h00000;
    next_result[`SAC_ST_INVERT] = (avg_high >= {9'h000, dur_total[8:1]});
    next_result[`SAC_ST_COARSE_MSB:`SAC_ST_COARSE_LSB] = edge_phase;
    next_result[`SAC_ST_FINE_MSB:`SAC_ST_FINE_LSB] = avg_high[7:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      enable <= 1'b0;
      cal_config <= `SAC_CFG_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SAC_ADDR_ENABLE)
        enable <= reg_wdata[0];
      if (reg_addr == `SAC_ADDR_CONFIG)
        cal_config <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // calibration sequencer

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      enable_prev <= 1'b0;
      sysref_prev <= 1'b0;
      state <= ST_IDLE;
      complete <= 1'b0;
      result <= 17'h00000;
      period_cnt <= 16'h0000;
      dur_cnt <= 9'h000;
      acc_cnt <= 9'h000;
      high_sum <= 17'h00000;
      edge_phase <= 8'h00;
      run_cnt <= 32'h00000000;
    end
    else
    begin
      enable_prev <= enable;
      sysref_prev <= sysref;
      if (sysref_rise)
        period_cnt <= 16'h0000;
      else if (period_cnt != 16'hffff)
        period_cnt <= period_cnt + 16'h0001;
      if (state == ST_WAIT || state == ST_ACCUM)
        run_cnt <= run_cnt + 32'h00000001;
      if (!enable)
      begin
        // result is kept so software can still read the last good delay
        complete <= 1'b0;
        state <= ST_IDLE;
      end
      else if (launch)
      begin
        complete <= 1'b0;
        state <= ST_WAIT;
        run_cnt <= 32'h00000000;
        acc_cnt <= 9'h000;
        high_sum <= 17'h00000;
        period_cnt <= 16'h0000;
      end
      else
      begin
        case (state)
          ST_WAIT:
          begin
            if (period_cnt > max_period || run_cnt >= run_limit)
              state <= ST_FAIL;
            else if (sysref_rise)
            begin
              edge_phase <= period_cnt[7:0];
              dur_cnt <= 9'h000;
              state <= ST_ACCUM;
            end
          end
          ST_ACCUM:
          begin
            if (period_cnt > max_period || run_cnt >= run_limit)
              state <= ST_FAIL;
            else
            begin
              high_sum <= high_sum + {16'h0000, sysref};
              dur_cnt <= dur_cnt + 9'h001;
              if (dur_cnt == dur_total - 9'h001)
              begin
                acc_cnt <= acc_cnt + 9'h001;
                if (acc_cnt == acc_total - 9'h001)
                begin
                  // a failed run never reaches here, so the old result stays
                  result <= next_result;
                  complete <= 1'b1;
                  state <= ST_DONE;
                end
                else
                  state <= ST_WAIT;
              end
            end
          end
          ST_DONE: state <= ST_DONE;
          ST_FAIL: state <= ST_FAIL;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and applied delay

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 24'h000000;
      sample_delay <= 17'h00000;
    end
    else
    begin
      case (reg_addr)
        `SAC_ADDR_ENABLE: reg_rdata <= {23'h000000, enable};
        `SAC_ADDR_CONFIG: reg_rdata <= {16'h0000, cal_config};
        `SAC_ADDR_STATUS: reg_rdata <= {6'h00, complete & enable, result};
        default: reg_rdata <= 24'h000000;
      endcase
      sample_delay <= enable ? result : manual_delay;
    end
  end

endmodule // sac_calibrator

`default_nettype wire

// ### bench/sac_props.sv
`timescale 1ns/1ps
`default_nettype none
module sac_props #(
  parameter [31:0] RUN_SCALE = 32'd7296
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  // delay
  input wire logic [16:0] manual_delay,
  input wire logic [16:0] sample_delay
);
  logic en_shadow;
  // shadow of the enable bit, since the checker cannot see inside
  always @(posedge clk)
  begin
    if (!rst_n)
      en_shadow <= 1'b0;
    else if (reg_wr && reg_addr == 12'h2b0)
      en_shadow <= reg_wdata[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cfg;
    reg_wr && reg_addr == 12'h2b1 ##1 reg_addr == 12'h2b1 && !reg_wr |=> reg_rdata == {16'h0000, $past(reg_wdata, 2)};
  endproperty
  property p_hi;
    $past(reg_addr) == 12'h2b1 |-> reg_rdata[23:8] == 16'h0000;
  endproperty
  property p_rsv;
    reg_rdata[23:18] == 6'h00;
  endproperty
  property p_unm;
    $past(reg_addr) > 12'h2b2 || $past(reg_addr) < 12'h2b0 |-> reg_rdata == 24'h000000;
  endproperty
  property p_clr;
    !en_shadow && !reg_wr && reg_addr == 12'h2b2 ##1 reg_addr == 12'h2b2 |=> !reg_rdata[17];
  endproperty
  property p_hold;
    en_shadow && !reg_wr && reg_addr == 12'h2b2 && reg_rdata[17] |=> reg_rdata[17];
  endproperty
  property p_dly;
    en_shadow && !reg_wr && reg_addr == 12'h2b2 && reg_rdata[17] |=> sample_delay == reg_rdata[16:0];
  endproperty
  property p_man;
    !en_shadow && $past(rst_n) |=> sample_delay == $past(manual_delay);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config readback wrong");
  a_hi: assert property (p_hi) else $error("config upper bits set");
  a_rsv: assert property (p_rsv) else $error("status reserved bits set");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_clr: assert property (p_clr) else $error("complete while disabled");
  a_hold: assert property (p_hold) else $error("complete dropped");
  a_dly: assert property (p_dly) else $error("applied delay not result");
  a_man: assert property (p_man) else $error("manual delay not applied");
  c_run: cover property (reg_rdata[17]);
  c_cfg: cover property (reg_wr && reg_addr == 12'h2b1);
  c_dis: cover property (reg_wr && reg_addr == 12'h2b0 && !reg_wdata[0]);
endmodule // sac_props
bind sac_calibrator sac_props #(.RUN_SCALE(RUN_SCALE)) u_sac_props (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .manual_delay(manual_delay), .sample_delay(sample_delay));
`default_nettype wire

// ### bench/sac_sysref_src.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sysref_src (
  // clock and period
  input wire logic clk,
  input wire logic [15:0] period,
  // reference
  output var logic sysref = 1'b0
);
  logic [15:0] cnt = 16'h0000;
  // free-running reference; a too long period is set on purpose by the bench
  always @(posedge clk)
  begin
    cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
    sysref <= (cnt < (period >> 1));
  end
endmodule // sac_sysref_src
`default_nettype wire

// ### bench/sac_calibrator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sac_calibrator_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [23:0] reg_rdata;
  logic sysref;
  logic [16:0] manual_delay = 17'h1a5a5;
  logic [16:0] sample_delay;
  logic [15:0] period = 16'h0008;
  logic [23:0] d;
  logic [23:0] keep;
  int err_count = 0;
  int compares = 0;
  int i;
  int n;
  always #5 clk = ~clk;
  // short run timeout scale keeps the bound checks quick
  sac_calibrator #(.RUN_SCALE(32'd8)) u_sac_calibrator (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sysref(sysref),
    .manual_delay(manual_delay), .sample_delay(sample_delay));
  sac_sysref_src u_sac_sysref_src (.clk(clk), .period(period), .sysref(sysref));
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // config first, then a fresh 0-to-1 on enable; poll status up to lim cycles
  task automatic run(input logic [7:0] c, input int lim);
    wr(12'h2b1, c);
    wr(12'h2b0, 8'h00);
    // no converter calibration exists in this bench, so it is idle here
    wr(12'h2b0, 8'h01);
    n = 0;
    do
    begin
      rd(12'h2b2);
      n += 2;
    end
    while (d[17] !== 1'b1 && n < lim);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rd(12'h2b1); chk(d, 24'h000005);
    rd(12'h2b2); chk(d, 24'h000000);
    rd(12'h2b7); chk(d, 24'h000000);
    wr(12'h2b1, 8'hf6); rd(12'h2b1); chk(d, 24'h0000f6);
    $display("test registers done");
    // every average and duration code, bound 8*4^(avg+dur+2)
    for (i = 0; i < 4; i++)
    begin
      run({4'h0, i[1:0], 2'(3 - i)}, 8 * (4 ** 5));
      chk({17'h00000, d[23:17]}, 24'h000001);
      // period 8 is high for 4 cycles: half of each window, the 4-cycle window sees 3
      chk({23'h000000, d[16]}, 24'h000001);
      chk({8'h00, d[15:0]}, {8'h00, 8'(period - 16'h0001), ((i == 3) ? 8'h03 : 8'(128 >> (2 * i)))});
      repeat (2) @(negedge clk);
      chk({7'h00, sample_delay}, {7'h00, d[16:0]});
    end
    keep = d;
    $display("test runs done");
    period = 16'd200;
    run(8'h00, 8 * 16 + 64);
    chk(d, {7'h00, keep[16:0]});
    wr(12'h2b0, 8'h00);
    rd(12'h2b2); chk(d, {7'h00, keep[16:0]});
    chk({7'h00, sample_delay}, {7'h00, manual_delay});
    $display("test failure and disable done");
    complete_run();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule // sac_calibrator_bench
`default_nettype wire
